// ==== src/sdl_defs.vh ====
// Constants for the serial DAC load interface
`ifndef SDL_DEFS_VH
`define SDL_DEFS_VH
`define SDL_WORD_BITS   16
`define SDL_BIT_CNT_W   5
`define SDL_LAST_BIT    5'h10
`define SDL_DATA_BITS   10
`define SDL_SUB_BITS    4
// Word layout: [15] control select, [14:12] channel, [11:0] payload
`define SDL_CTL_BIT     15
`define SDL_CH_HI       14
`define SDL_CH_LO       12
`define SDL_CH_W        3
// Control payload: [0] external reference, [4:1] sub DAC offset
`define SDL_CTL_REF_BIT 0
`define SDL_CTL_SUB_HI  4
`define SDL_CTL_SUB_LO  1
`define SDL_CLEAR_CODE  10'h200
`define SDL_SUB_ZERO    4'h0
`define SDL_ZERO_WORD   16'h0000
`endif

// ==== src/sdl_sync2.v ====
// Two flip-flop synchroniser for one level
`timescale 1ns/1ns
`include "sdl_defs.vh"
module sdl_sync2 (
	input  wire clk,
	input  wire rst_n,
	input  wire rst_val,
	input  wire d,
	output wire q
);
	reg meta_reg;
	reg sync_reg;
	// Inverting through rst_val lets the flops reset to zero yet idle at the pin's level
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= d ^ rst_val;
			sync_reg <= meta_reg;
		end
	end
	assign q = sync_reg ^ rst_val;
endmodule // sdl_sync2

// ==== src/sdl_serial_dac_load.v ====
// Serial word loader, data/control registers and DAC registers
// Summary of operation
// - The shift register is enabled only while frame_sync_n is low.
// - Each 16-bit word is shifted in MSB first on falling serial clock edges.
// - Load_outputs_n low copies every data register to its DAC register at once.
// - Load_outputs_n low at the sixteenth edge triggers an automatic update.
// - Async_clear_n low clears main DACs to mid code and sub DACs to zero.
// - Power_down_n low puts the device into low-power mode.
// - Each channel's control register selects the external reference.
`timescale 1ns/1ns
`include "sdl_defs.vh"
module sdl_serial_dac_load #(
	parameter CHANNELS = 8
) (
	input  wire                               sys_clk,
	input  wire                               rst_n,
	input  wire                               frame_sync_n,
	input  wire                               serial_clock_in,
	input  wire                               serial_data_in,
	input  wire                               load_outputs_n,
	input  wire                               async_clear_n,
	input  wire                               power_down_n,
	output reg  [CHANNELS*`SDL_DATA_BITS-1:0] dac_codes,
	output reg  [CHANNELS*`SDL_SUB_BITS-1:0]  sub_codes,
	output reg  [CHANNELS-1:0]                ext_ref_sel,
	output reg                                low_power,
	output reg                                word_done
);
	reg                                rst_meta_reg;
	reg                                rst_sync_reg;
	wire                               fs_n_s;
	wire                               sck_s;
	wire                               sdi_s;
	wire                               ld_n_s;
	wire                               clr_n_s;
	wire                               pd_n_s;
	reg                                sck_prev_reg;
	reg  [`SDL_WORD_BITS-1:0]          shift_reg;
	reg  [`SDL_BIT_CNT_W-1:0]          count_reg;
	wire                               fall;
	wire [`SDL_WORD_BITS-1:0]          word_full;
	wire                               complete;
	wire [CHANNELS*`SDL_DATA_BITS-1:0] data_fwd;
	wire [CHANNELS*`SDL_SUB_BITS-1:0]  sub_fwd;
	wire [CHANNELS-1:0]                ref_fwd;
	genvar                             k;

	// One decode for both kinds of write, so they never disagree on the channel
	function sdl_hit;
		input [`SDL_WORD_BITS-1:0] word;
		input integer              chan;
		input                      want_ctl;
		begin
			sdl_hit = (word[`SDL_CH_HI:`SDL_CH_LO] == chan) &&
				(word[`SDL_CTL_BIT] == want_ctl);
		end
	endfunction

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	sdl_sync2 u_fs (
		.clk     (sys_clk),
		.rst_n   (rst_sync_reg),
		.rst_val (1'b1),
		.d       (frame_sync_n),
		.q       (fs_n_s)
	);

	sdl_sync2 u_sck (
		.clk     (sys_clk),
		.rst_n   (rst_sync_reg),
		.rst_val (1'b1),
		.d       (serial_clock_in),
		.q       (sck_s)
	);

	sdl_sync2 u_sdi (
		.clk     (sys_clk),
		.rst_n   (rst_sync_reg),
		.rst_val (1'b0),
		.d       (serial_data_in),
		.q       (sdi_s)
	);

	sdl_sync2 u_ld (
		.clk     (sys_clk),
		.rst_n   (rst_sync_reg),
		.rst_val (1'b1),
		.d       (load_outputs_n),
		.q       (ld_n_s)
	);

	// Clear acts on the synchronised level; three-cycle latency at most
	sdl_sync2 u_clr (
		.clk     (sys_clk),
		.rst_n   (rst_sync_reg),
		.rst_val (1'b1),
		.d       (async_clear_n),
		.q       (clr_n_s)
	);

	sdl_sync2 u_pd (
		.clk     (sys_clk),
		.rst_n   (rst_sync_reg),
		.rst_val (1'b1),
		.d       (power_down_n),
		.q       (pd_n_s)
	);

	// Data and serial clock share synchroniser depth, so data is sampled aligned
	assign fall      = sck_prev_reg & ~sck_s & ~fs_n_s;
	assign word_full = {shift_reg[`SDL_WORD_BITS-2:0], sdi_s};
	assign complete  = fall && (count_reg == `SDL_LAST_BIT - 5'h01);

	always @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			sck_prev_reg <= 1'b1;
			shift_reg    <= `SDL_ZERO_WORD;
			count_reg    <= {`SDL_BIT_CNT_W{1'b0}};
		end else begin
			sck_prev_reg <= sck_s;
			if (fs_n_s) begin
				count_reg <= {`SDL_BIT_CNT_W{1'b0}};
			end else if (fall) begin
				shift_reg <= word_full;
				count_reg <= complete ? {`SDL_BIT_CNT_W{1'b0}} : count_reg + 5'h01;
			end
		end
	end

	generate
		for (k = 0; k < CHANNELS; k = k + 1) begin : g_ch
			reg  [`SDL_DATA_BITS-1:0] data_reg;
			reg  [`SDL_SUB_BITS-1:0]  sub_reg;
			reg                       ref_reg;
			wire                      data_wr;
			wire                      ctl_wr;

			assign data_wr = complete && sdl_hit(word_full, k, 1'b0);
			assign ctl_wr  = complete && sdl_hit(word_full, k, 1'b1);

			always @(posedge sys_clk or negedge rst_sync_reg) begin
				if (!rst_sync_reg) begin
					data_reg <= `SDL_CLEAR_CODE;
				end else if (!clr_n_s) begin
					data_reg <= `SDL_CLEAR_CODE;
				end else if (data_wr) begin
					data_reg <= word_full[`SDL_DATA_BITS-1:0];
				end
			end

			always @(posedge sys_clk or negedge rst_sync_reg) begin
				if (!rst_sync_reg) begin
					sub_reg <= `SDL_SUB_ZERO;
				end else if (!clr_n_s) begin
					sub_reg <= `SDL_SUB_ZERO;
				end else if (ctl_wr) begin
					sub_reg <= word_full[`SDL_CTL_SUB_HI:`SDL_CTL_SUB_LO];
				end
			end

			always @(posedge sys_clk or negedge rst_sync_reg) begin
				if (!rst_sync_reg) begin
					ref_reg <= 1'b0;
				end else if (ctl_wr) begin
					ref_reg <= word_full[`SDL_CTL_REF_BIT];
				end
			end

			// Completed word is forwarded so outputs move on the word_done edge
			assign data_fwd[k*`SDL_DATA_BITS +: `SDL_DATA_BITS] =
				data_wr ? word_full[`SDL_DATA_BITS-1:0] : data_reg;
			assign sub_fwd[k*`SDL_SUB_BITS +: `SDL_SUB_BITS] =
				ctl_wr ? word_full[`SDL_CTL_SUB_HI:`SDL_CTL_SUB_LO] : sub_reg;
			assign ref_fwd[k] = ctl_wr ? word_full[`SDL_CTL_REF_BIT] : ref_reg;
		end
	endgenerate

	always @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			word_done <= 1'b0;
		end else begin
			word_done <= complete;
		end
	end

	always @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			low_power <= 1'b0;
		end else begin
			low_power <= ~pd_n_s;
		end
	end

	always @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ext_ref_sel <= {CHANNELS{1'b0}};
		end else begin
			ext_ref_sel <= ref_fwd;
		end
	end

	always @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			sub_codes <= {CHANNELS*`SDL_SUB_BITS{1'b0}};
		end else if (!clr_n_s) begin
			sub_codes <= {CHANNELS*`SDL_SUB_BITS{1'b0}};
		end else begin
			sub_codes <= sub_fwd;
		end
	end

	// Clear wins over load so a held-low load cannot fight it
	always @(posedge sys_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			dac_codes <= {CHANNELS{`SDL_CLEAR_CODE}};
		end else if (!clr_n_s) begin
			dac_codes <= {CHANNELS{`SDL_CLEAR_CODE}};
		end else if (!ld_n_s) begin
			dac_codes <= data_fwd;
		end
	end
endmodule // sdl_serial_dac_load

// ==== testbench/sdl_checker_asserts.sv ====
// Port assertions for the serial DAC loader
`timescale 1ns/1ns
module sdl_checker #(parameter CHANNELS = 8) (
	input logic                   sys_clk,
	input logic                   rst_n,
	input logic                   frame_sync_n,
	input logic                   load_outputs_n,
	input logic                   async_clear_n,
	input logic                   power_down_n,
	input logic                   low_power,
	input logic                   word_done,
	input logic [CHANNELS*10-1:0] dac_codes,
	input logic [CHANNELS*4-1:0]  sub_codes,
	input logic [CHANNELS-1:0]    ext_ref_sel
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_pdon; !power_down_n [*4] |-> low_power; endproperty
	a_pdon: assert property (p_pdon) else $error("no low power");
	property p_pdoff; power_down_n [*4] |-> !low_power; endproperty
	a_pdoff: assert property (p_pdoff) else $error("low power stuck");
	property p_clr; !async_clear_n [*4] |-> dac_codes == {CHANNELS{10'h200}} && sub_codes == 0;
	endproperty
	a_clr: assert property (p_clr) else $error("clear missed");
	property p_idle; frame_sync_n [*8] |-> !word_done; endproperty
	a_idle: assert property (p_idle) else $error("word outside frame");
	property p_inf; word_done |-> !$past(frame_sync_n, 6); endproperty
	a_inf: assert property (p_inf) else $error("word without frame");
	property p_gap; word_done |=> !word_done [*8]; endproperty
	a_gap: assert property (p_gap) else $error("words too close");
	property p_ld; $changed(dac_codes) |-> !$past(load_outputs_n, 3) || !$past(async_clear_n, 3);
	endproperty
	a_ld: assert property (p_ld) else $error("codes moved without load");
	property p_ctl; $changed({sub_codes, ext_ref_sel}) |-> word_done || !$past(async_clear_n, 3);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control moved alone");
	c_auto: cover property (word_done && !load_outputs_n);
	c_clr: cover property (!async_clear_n);
	c_pd: cover property (low_power);
endmodule // sdl_checker
bind sdl_serial_dac_load sdl_checker #(.CHANNELS(CHANNELS)) u_chk (.*);

// ==== testbench/sdl_host.sv ====
// Host model framing words onto the serial load pins
`timescale 1ns/1ns
module sdl_host (
	input wire sys_clk,
	output reg frame_sync_n = 1'b1,
	output reg serial_clock_in = 1'b1,
	output reg serial_data_in = 1'b0
);
	// Clock stands high between frames, data flips after release
	task send(input [15:0] w, input integer n);
		integer i;
		frame_sync_n <= 1'b0;
		for (i = 15; i > 15 - n; i--) begin
			serial_data_in <= w[i];
			repeat (4) @(posedge sys_clk);
			serial_clock_in <= 1'b0;
			repeat (4) @(posedge sys_clk);
			serial_clock_in <= 1'b1;
		end
		frame_sync_n <= 1'b1;
		serial_data_in <= ~serial_data_in;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule // sdl_host

// ==== testbench/test_serial_dac_load_interface.sv ====
// Self-checking bench for the serial DAC loader
`timescale 1ns/1ns
module test_serial_dac_load_interface;
	reg sys_clk = 1'b0, rst_n = 1'b0, load_outputs_n = 1'b0;
	reg async_clear_n = 1'b1, power_down_n = 1'b1;
	wire frame_sync_n, serial_clock_in, serial_data_in, low_power, word_done;
	wire [79:0] dac_codes;
	wire [31:0] sub_codes;
	wire [7:0] ext_ref_sel;
	reg [31:0] q[$], m;
	reg [15:0] w;
	reg [2:0] c;
	integer n_mismatch = 0, tests_run = 0, seed = 12, i;
	sdl_host u_host (.*);
	sdl_serial_dac_load u_dut (.*);
	task chk(input [111:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task final_report;
		if (q.size() != 0) n_mismatch++;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial forever #10 sys_clk = ~sys_clk;
	initial begin
		#400000;
		n_mismatch++;
		final_report;
	end
	// A word with nothing queued reads as all ones and fails
	always @(negedge sys_clk) if (word_done === 1'b1) begin
		m = q.size() ? q.pop_front() : '1;
		c = m[14:12];
		chk(m[15] ? {sub_codes[c*4+:4], ext_ref_sel[c]} : dac_codes[c*10+:10], m[31:16]);
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (i = 0; i < 16; i++) begin
			w = $random(seed);
			w[15:12] = i[3:0];
			q.push_back({w[15] ? {11'h0, w[4:0]} : {6'h0, w[9:0]}, w});
			u_host.send(w, 16);
		end
		$display("auto load and control words done");
		q.push_back({16'h0155, 16'h2155});
		u_host.send(16'h2155, 16);
		load_outputs_n <= 1'b1;
		q.push_back({16'h0155, 16'h22AA});
		u_host.send(16'h22AA, 16);
		load_outputs_n <= 1'b0;
		repeat (6) @(negedge sys_clk);
		chk(dac_codes[29:20], 10'h2AA);
		$display("explicit load done");
		@(posedge sys_clk);
		u_host.send(16'hFFFF, 9);
		q.push_back({16'h0011, 16'h1011});
		u_host.send(16'h1011, 16);
		$display("aborted frame done");
		async_clear_n <= 1'b0;
		repeat (6) @(negedge sys_clk);
		chk({dac_codes, sub_codes}, {{8{10'h200}}, 32'h0});
		@(posedge sys_clk) async_clear_n <= 1'b1;
		power_down_n <= 1'b0;
		repeat (5) @(negedge sys_clk);
		chk(low_power, 1'b1);
		@(posedge sys_clk) power_down_n <= 1'b1;
		repeat (5) @(negedge sys_clk);
		chk(low_power, 1'b0);
		$display("clear and power-down done");
		final_report;
	end
endmodule // test_serial_dac_load_interface
